// [rtl/card_socket_power_irq_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module card_socket_power_irq_ctrl
	import socket_ctrl_pkg::*;
(
	input  wire logic                 i_clk,
	input  wire logic                 i_sys_rst,
	input  wire reg_req_s             i_reg_req,
	output logic [7:0]                o_reg_rdata,
	input  wire logic                 i_battery_detect1_ring_pin_n,
	input  wire logic                 i_card_is_16bit,
	input  wire logic                 i_card_func_irq,
	input  wire logic                 i_card_status_change,
	input  wire logic [3:0]           i_status_change_irq_select,
	output logic                      o_card_output_enable,
	output logic [1:0]                o_socket_vcc_request,
	output logic [1:0]                o_socket_vpp_request,
	output logic                      o_ring_indicate,
	output logic                      o_card_reset,
	output logic                      o_card_is_io,
	output logic                      o_pci_irq,
	output logic                      o_smi,
	output logic [IRQ_LINES-1:0]      o_legacy_irq
);

	// ******************************************************************
	// Pin synchronisers.
	// ******************************************************************
	logic [2:0] pins_sync;

	pin_sync2 #(.WIDTH(3)) u_pin_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_battery_detect1_ring_pin_n, i_card_is_16bit, i_card_func_irq}),
		.o_sync    (pins_sync)
	);

	wire ring_pin_n_s = pins_sync[2];
	wire card16_s     = pins_sync[1];
	wire func_irq_s   = pins_sync[0];

	// ******************************************************************
	// Register file.
	// ******************************************************************
	logic [7:0] power_reg;
	logic [7:0] power_next;
	logic [7:0] int_gen_reg;
	logic [7:0] int_gen_next;
	logic [7:0] rdata_next;

	wire wr_power   = i_reg_req.wr && (i_reg_req.addr == POWER_OFFSET);
	wire wr_int_gen = i_reg_req.wr && (i_reg_req.addr == INT_GEN_OFFSET);

	// Reserved bits never store, so they read back as zero.
	assign power_next   = wr_power ? (i_reg_req.wdata & POWER_WRITE_MASK) : power_reg;
	assign int_gen_next = wr_int_gen ? i_reg_req.wdata : int_gen_reg;

	// Unmapped offsets read as zero.
	assign rdata_next = (i_reg_req.addr == POWER_OFFSET)   ? power_reg :
	                    (i_reg_req.addr == INT_GEN_OFFSET) ? int_gen_reg : REG_RESET;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			power_reg   <= REG_RESET;
			int_gen_reg <= REG_RESET;
			o_reg_rdata <= REG_RESET;
		end else begin
			power_reg   <= power_next;
			int_gen_reg <= int_gen_next;
			if (i_reg_req.rd) begin
				o_reg_rdata <= rdata_next;
			end
		end
	end

	// ******************************************************************
	// Power requests and card control decode.
	// ******************************************************************
	wire [1:0] vcc_field             = power_reg[VCC_HI:VCC_LO];
	wire [1:0] vpp_field             = power_reg[VPP_HI:VPP_LO];
	wire [3:0] functional_irq_select = int_gen_reg[SEL_HI:0];

	// Only the 5 V and 3.3 V codes actually power the socket.
	wire vcc_on = (vcc_field == VCC_5V) || (vcc_field == VCC_3V3);

	// A stale programming code must not reach the switch while unpowered.
	wire [1:0] vpp_eff = vcc_on ? vpp_field : VPP_OFF;

	// Ring indicate is the active-low pin level, gated by the enable.
	wire ring_now = int_gen_reg[RING_EN_BIT] && !ring_pin_n_s;

	// Non 16-bit cards never see the reset.
	wire reset_now = !int_gen_reg[RESET_OFF_BIT] && card16_s;

	// Select 0000 also forces status-change to PCI for older software.
	wire status_change_to_pci = int_gen_reg[STATUS_TO_PCI_BIT] || (functional_irq_select == SEL_NONE);

	// Decode a select code to SMI or one IRQ line.
	function automatic logic [IRQ_LINES:0] route(input logic [3:0] sel);
		logic [IRQ_LINES:0] v;
		v = '0;
		if (sel == SEL_SMI) begin
			v[IRQ_LINES] = 1'b1;
		end else if (sel != SEL_NONE) begin
			v[sel] = 1'b1;
		end
		return v;
	endfunction : route

	// Functional interrupts exist only for I/O cards; status changes not sent to PCI use their own select.
	wire                func_active          = func_irq_s && int_gen_reg[CARD_IO_BIT];
	wire [IRQ_LINES:0]  func_vec             = func_active ? route(functional_irq_select) : '0;
	wire                status_change_legacy = i_card_status_change && !status_change_to_pci;
	wire [IRQ_LINES:0]  status_change_vec    = status_change_legacy ? route(i_status_change_irq_select) : '0;
	wire [IRQ_LINES:0]  irq_vec              = func_vec | status_change_vec;

	// Outputs are registered so pins never glitch during register writes.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_card_output_enable <= 1'b0;
			o_socket_vcc_request <= VCC_0V;
			o_socket_vpp_request <= VPP_OFF;
			o_ring_indicate      <= 1'b0;
			o_card_reset         <= 1'b0;
			o_card_is_io         <= 1'b0;
			o_pci_irq            <= 1'b0;
			o_smi                <= 1'b0;
			o_legacy_irq         <= '0;
		end else begin
			o_card_output_enable <= power_reg[OE_BIT];
			o_socket_vcc_request <= vcc_field;
			o_socket_vpp_request <= vpp_eff;
			o_ring_indicate      <= ring_now;
			o_card_reset         <= reset_now;
			o_card_is_io         <= int_gen_reg[CARD_IO_BIT];
			o_pci_irq            <= i_card_status_change && status_change_to_pci;
			o_smi                <= irq_vec[IRQ_LINES];
			o_legacy_irq         <= irq_vec[IRQ_LINES-1:0];
		end
	end

	// ******************************************************************
	// Checks.
	// ******************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_oe_follows_write;
		wr_power && i_reg_req.wdata[OE_BIT] ##1 !wr_power |=> o_card_output_enable;
	endproperty
	a_oe_follows_write: assert property (p_oe_follows_write) else $error("Output enable missed write.");

	property p_rsvd_65;
		i_reg_req.rd && (i_reg_req.addr == POWER_OFFSET) |=> o_reg_rdata[6:5] == 2'h0;
	endproperty
	a_rsvd_65: assert property (p_rsvd_65) else $error("Power bits 6..5 read nonzero.");

	property p_vcc_request;
		wr_power ##1 !wr_power |=> o_socket_vcc_request == $past(i_reg_req.wdata[VCC_HI:VCC_LO], 2);
	endproperty
	a_vcc_request: assert property (p_vcc_request) else $error("Supply request wrong.");

	property p_rsvd_2;
		i_reg_req.rd && (i_reg_req.addr == POWER_OFFSET) |=> !o_reg_rdata[2];
	endproperty
	a_rsvd_2: assert property (p_rsvd_2) else $error("Power bit 2 read nonzero.");

	property p_vpp_12v;
		wr_power && (i_reg_req.wdata[4:0] == 5'h12) ##1 !wr_power |=> o_socket_vpp_request == VPP_12V;
	endproperty
	a_vpp_12v: assert property (p_vpp_12v) else $error("12 V request lost.");

	property p_vpp_gated;
		!$past(vcc_on) |-> o_socket_vpp_request == VPP_OFF;
	endproperty
	a_vpp_gated: assert property (p_vpp_gated) else $error("Vpp driven with supply off.");

	property p_ring;
		o_ring_indicate |-> $past(int_gen_reg[RING_EN_BIT]) && !$past(ring_pin_n_s);
	endproperty
	a_ring: assert property (p_ring) else $error("Ring indicate without enable.");

	property p_reset;
		o_card_reset == $past(reset_now);
	endproperty
	a_reset: assert property (p_reset) else $error("Card reset wrong.");

	// A status change sent to PCI must not also reach a legacy line unless a functional interrupt is up.
	property p_pci_route;
		i_card_status_change && (int_gen_reg[STATUS_TO_PCI_BIT] || functional_irq_select == SEL_NONE) |=>
			o_pci_irq && ($past(func_active) || (!o_smi && o_legacy_irq == 16'h0000));
	endproperty
	a_pci_route: assert property (p_pci_route) else $error("Status change not sent to PCI.");

	property p_status_change_smi;
		i_card_status_change && !status_change_to_pci && i_status_change_irq_select == SEL_SMI |=> o_smi && !o_pci_irq;
	endproperty
	a_status_change_smi: assert property (p_status_change_smi) else $error("Status change not sent to SMI.");

	property p_func_irq3;
		func_irq_s && int_gen_reg[CARD_IO_BIT] && functional_irq_select == 4'h3 && !i_card_status_change |=>
			o_legacy_irq == 16'h0008;
	endproperty
	a_func_irq3: assert property (p_func_irq3) else $error("IRQ3 select wrong.");

	property p_memory_card_quiet;
		!int_gen_reg[CARD_IO_BIT] && !i_card_status_change |=> !o_smi && o_legacy_irq == 16'h0000;
	endproperty
	a_memory_card_quiet: assert property (p_memory_card_quiet) else $error("Memory card raised IRQ.");

endmodule : card_socket_power_irq_ctrl
`default_nettype wire

// [inc/socket_ctrl_pkg.sv]
package socket_ctrl_pkg;

	// ******************************************************************
	// Register map and field layout.
	// ******************************************************************
	localparam logic [7:0] POWER_OFFSET        = 8'h02;
	localparam logic [7:0] INT_GEN_OFFSET      = 8'h03;
	localparam logic [7:0] REG_RESET           = 8'h00;
	localparam logic [7:0] POWER_WRITE_MASK    = 8'h9B;
	localparam int         OE_BIT              = 7;
	localparam int         VCC_HI              = 4;
	localparam int         VCC_LO              = 3;
	localparam int         VPP_HI              = 1;
	localparam int         VPP_LO              = 0;
	localparam int         RING_EN_BIT         = 7;
	localparam int         RESET_OFF_BIT       = 6;
	localparam int         CARD_IO_BIT         = 5;
	localparam int         STATUS_TO_PCI_BIT   = 4;
	localparam int         SEL_HI              = 3;

	// ******************************************************************
	// Supply and programming voltage codes.
	// ******************************************************************
	localparam logic [1:0] VCC_0V              = 2'h0;
	localparam logic [1:0] VCC_0V_RSVD         = 2'h1;
	localparam logic [1:0] VCC_5V              = 2'h2;
	localparam logic [1:0] VCC_3V3             = 2'h3;
	localparam logic [1:0] VPP_OFF             = 2'h0;
	localparam logic [1:0] VPP_FOLLOW_VCC      = 2'h1;
	localparam logic [1:0] VPP_12V             = 2'h2;

	// ******************************************************************
	// Interrupt select codes.
	// ******************************************************************
	localparam logic [3:0] SEL_NONE            = 4'h0;
	localparam logic [3:0] SEL_SMI             = 4'h2;
	localparam int         IRQ_LINES           = 16;

	// Byte register access carried as one bundle.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage : socket_ctrl_pkg

// [rtl/pin_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;

	// Two stages; only the second stage is read outside this module.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end

endmodule : pin_sync2
`default_nettype wire

// [bench/card_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Behavioural 16-bit card: drives its pins one cycle after the bench asks.
module card_model (
	input  wire logic i_clk,
	input  wire logic i_present,
	input  wire logic i_ring,
	input  wire logic i_irq,
	output logic      o_ring_pin_n,
	output logic      o_func_irq,
	output logic      o_is_16bit
);
	// An absent card releases its pins, so the pull-up and pull-down set them.
	always_ff @(posedge i_clk) begin
		o_ring_pin_n <= i_present ? ~i_ring : 1'b1;
		o_func_irq   <= i_present & i_irq;
		o_is_16bit   <= i_present;
	end
endmodule : card_model
`default_nettype wire

// [bench/card_socket_power_irq_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module card_socket_power_irq_ctrl_bench
	import socket_ctrl_pkg::*;
;
	logic        i_clk = 0, i_sys_rst = 1, sc = 0, pin_n, fi, is16;
	logic        present = 0, ring = 0, irq = 0, snap = 0, rd_d = 0;
	logic [3:0]  scsel = 0;
	logic [7:0]  rdata;
	logic [15:0] lirq;
	logic [1:0]  vcc, vpp;
	logic        oe, ri, crst, io, pci, smi;
	reg_req_s    req = '0;
	logic [25:0] exp_q[$];
	logic [31:0] seed = 32'h00011CCB; // Starts at 72907.
	int          fails = 0, checks = 0;
	wire  [25:0] outs = {oe, vcc, vpp, ri, crst, io, pci, smi, lirq};

	// ****************************************
	// Clock, design and card.
	// ****************************************
	always #25 i_clk = ~i_clk;
	card_socket_power_irq_ctrl card_socket_power_irq_ctrl_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_reg_req(req), .o_reg_rdata(rdata), .i_battery_detect1_ring_pin_n(pin_n), .i_card_is_16bit(is16),
		.i_card_func_irq(fi), .i_card_status_change(sc), .i_status_change_irq_select(scsel),
		.o_card_output_enable(oe), .o_socket_vcc_request(vcc), .o_socket_vpp_request(vpp), .o_ring_indicate(ri),
		.o_card_reset(crst), .o_card_is_io(io), .o_pci_irq(pci), .o_smi(smi), .o_legacy_irq(lirq));
	card_model card_model_inst (.i_clk(i_clk), .i_present(present), .i_ring(ring), .i_irq(irq),
		.o_ring_pin_n(pin_n), .o_func_irq(fi), .o_is_16bit(is16));

	// ****************************************
	// Expectation helpers.
	// ****************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Code two is the SMI line, every other nonzero code its own IRQ line.
	function automatic logic [16:0] dec(input logic [3:0] s);
		dec = '0;
		if (s == 4'h2) dec[16] = 1'b1;
		else if (s != 4'h0) dec[s] = 1'b1;
	endfunction : dec

	function automatic logic [25:0] expect_out(input logic [7:0] p, input logic [7:0] c);
		logic [16:0] r;
		logic        to_pci;
		r = (c[5] && present && irq) ? dec(c[3:0]) : 17'h0;
		to_pci = sc && (c[4] || c[3:0] == 4'h0);
		if (sc && !to_pci) r = r | dec(scsel);
		return {p[7], p[4:3], p[4] ? p[1:0] : 2'h0, c[7] & present & ring, ~c[6] & present, c[5], to_pci, r};
	endfunction : expect_out

	task automatic check(input logic [25:0] seen, input logic [25:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// ****************************************
	// Bus and stimulus tasks.
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) req <= {2'b10, a, d};
		@(posedge i_clk) req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({18'h0, e});
		@(posedge i_clk) req <= {2'b01, a, 8'h00};
		@(posedge i_clk) req.rd <= 1'b0;
	endtask : rd

	// Waits out the two-flop pin synchronisers before sampling the outputs.
	task automatic snapshot(input logic [7:0] p, input logic [7:0] c);
		repeat (4) @(posedge i_clk);
		exp_q.push_back(expect_out(p, c));
		snap <= 1'b1;
		@(posedge i_clk) snap <= 1'b0;
	endtask : snapshot

	task automatic apply(input logic [7:0] p, input logic [7:0] c, input logic [31:0] v);
		@(posedge i_clk) {scsel, sc, irq, ring, present} <= v[7:0];
		wr(8'h02, p);
		wr(8'h03, c);
		rd(8'h02, p & 8'h9B);
		rd(8'h03, c);
		snapshot(p, c);
	endtask : apply

	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// A read answers one edge after it is taken; a snapshot is compared when flagged.
	always @(posedge i_clk) begin
		if (rd_d) check({18'h0, rdata}, exp_q.pop_front(), "read data");
		else if (snap) check(outs, exp_q.pop_front(), "outputs");
		rd_d <= req.rd;
	end

	// Main sequence: defaults, an unmapped place, every code, then random settings.
	initial begin
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		snapshot(8'h00, 8'h00);
		wr(8'h07, 8'hFF);
		rd(8'h07, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h00);
		// Directed: 12 V at 5 V with IRQ3, status change to SMI, and status change to PCI.
		apply(8'h92, 8'h63, 32'h00000005);
		apply(8'h1A, 8'h21, 32'h0000002D);
		apply(8'h88, 8'h90, 32'h0000002D);
		for (int i = 0; i < 16; i++) begin
			apply({i[0], 2'b11, i[3:2], 1'b1, i[1:0]}, {i[1], i[2], 2'b10, i[3:0]}, xs() | 32'h5);
		end
		repeat (24) apply(8'(xs()), 8'(xs()), xs());
		summarize();
	end

	// The whole run needs about 620 cycles; this is about sixteen times that.
	initial begin
		#500000;
		fails++;
		summarize();
	end
endmodule : card_socket_power_irq_ctrl_bench
`default_nettype wire
